/* hdl/tgc_timer.sv */
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// R1: Prescaler divides clock by 1,2,4,8
// R2: Oscillator enable bit drives oscillator output
// R3: Run bit enables counting; clear holds count
// R4: Gate enable matters only while running
// R5: Toggle flop flips on rising gate edges
// R6: Single-pulse bit hands gate to pulse logic
// R7: Software arms go bit; hardware clears it
// R8: Gate source selects pin or 8-bit overflow
// R9: Go bit clears on falling gate value
// R10: Falling gate value sets gate event flag
// R11: Counter wraps FFFF to 0000, flags overflow
// R12: External clock synchronized unless sync_n set; code passes the two pin flops in both modes
// R13: Polarity picks active level; value readable
module tgc_timer
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and neighbours
  input  wire logic        ext_clock_pin,
  input  wire logic        gate_pin,
  input  wire logic        tmr8_overflow,
  output logic             low_power_osc_on,
  // Interrupt
  output logic             irq
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]  timer_control;
  logic [7:0]  timer_gate_control;
  logic [15:0] count;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        go_done;
  logic        toggle_q;
  logic        pulse_q;
  logic        gate_value_q;
  logic        ext_sync_q;
  logic        ext_raw_q;
  logic        gsrc_q;

  // ****************************************
  // Field decode
  // ****************************************
  wire [1:0] clock_source_select    = timer_control[tgc_pkg::CS_LSB +: 2];
  wire [1:0] input_prescale_select  = timer_control[tgc_pkg::CKPS_LSB +: 2];
  wire       low_power_osc_enable   = timer_control[tgc_pkg::OSCEN_BIT];
  wire       external_clock_sync_n  = timer_control[tgc_pkg::SYNCN_BIT];
  wire       timer_run              = timer_control[tgc_pkg::RUN_BIT];
  wire       gate_enable            = timer_gate_control[tgc_pkg::GE_BIT];
  wire       gate_polarity          = timer_gate_control[tgc_pkg::GPOL_BIT];
  wire       gate_toggle_mode       = timer_gate_control[tgc_pkg::GTM_BIT];
  wire       gate_single_pulse_mode = timer_gate_control[tgc_pkg::GSPM_BIT];
  wire [1:0] gate_source_select     = timer_gate_control[tgc_pkg::GSS_LSB +: 2];

  // ****************************************
  // APB decode
  // ****************************************
  wire wr_en  = psel && penable && pwrite;
  wire rd_en  = psel && penable && !pwrite;
  // One compare per register, shared by write, read and error decode
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  wire hit_tc  = reg_hit(paddr, tgc_pkg::ADDR_TIMER_CONTROL);
  wire hit_gc  = reg_hit(paddr, tgc_pkg::ADDR_GATE_CONTROL);
  wire hit_cl  = reg_hit(paddr, tgc_pkg::ADDR_COUNT_LOW);
  wire hit_ch  = reg_hit(paddr, tgc_pkg::ADDR_COUNT_HIGH);
  wire hit_is  = reg_hit(paddr, tgc_pkg::ADDR_IRQ_STATUS);
  wire hit_im  = reg_hit(paddr, tgc_pkg::ADDR_IRQ_MASK);
  wire hit_any = hit_tc || hit_gc || hit_cl || hit_ch || hit_is || hit_im;
  wire lane0   = pstrb[0];

  // Only byte lane 0 carries register bits; other lanes are ignored
  wire wr_tc = wr_en && hit_tc && lane0;
  wire wr_gc = wr_en && hit_gc && lane0;
  wire wr_im = wr_en && hit_im && lane0;

  // Zero wait states; unmapped offsets answer with an error and read zero
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ****************************************
  // Clock source and sync
  // ****************************************
  // Both pins are asynchronous: two flops each before any logic reads them
  wire [1:0] pin_raw = {gate_pin, ext_clock_pin};
  wire [1:0] pin_sync;

  for (genvar g = 0; g < 2; g++)
  begin : g_pin_sync
    logic meta_q;
    logic sync_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end
      else
      begin
        meta_q <= pin_raw[g];
        sync_q <= meta_q;
      end
    end
    assign pin_sync[g] = sync_q;
  end

  wire ext_sync  = pin_sync[0];
  wire gpin_sync = pin_sync[1];

  // Edge stages behind the synchronizer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync_q <= 1'b0;
      ext_raw_q  <= 1'b0;
    end
    else
    begin
      ext_sync_q <= ext_sync;
      ext_raw_q  <= ext_sync_q;
    end
  end

  // Single clock, so both modes pass the two pin flops. Synchronized mode
  // adds one alignment stage; unsynchronized mode counts a cycle earlier.
  wire ext_rise_sync  = ext_sync_q && !ext_raw_q;
  wire ext_rise_async = ext_sync && !ext_sync_q;
  // Internal sources tick on every pclk
  wire ext_tick       = external_clock_sync_n ? ext_rise_async : ext_rise_sync; // [R12]
  wire src_tick       = (clock_source_select[1]) ? ext_tick : 1'b1;            // [R12]

  // ****************************************
  // Gate path
  // ****************************************
  // Polarity applied in one place for the live and the delayed source
  function automatic logic active_level(input logic polarity, input logic level);
    active_level = polarity ? level : !level;
  endfunction : active_level

  // Reserved source codes hold the gate source low
  wire gsrc = (gate_source_select == tgc_pkg::GSS_TMR8) ? tmr8_overflow    // [R8]
            : (gate_source_select == tgc_pkg::GSS_PIN)  ? gpin_sync : 1'b0;
  // Edges judged after polarity, so a rise always opens an active phase
  wire gpol      = active_level(gate_polarity, gsrc);                      // [R13]
  wire gpol_q    = active_level(gate_polarity, gsrc_q);
  wire gate_rise = gpol && !gpol_q;
  wire after_tgl = gate_toggle_mode ? toggle_q : gpol;                     // [R5]
  wire gate_cur  = gate_single_pulse_mode ? pulse_q : after_tgl;           // [R6]
  wire gval_fall = gate_value_q && !gate_cur;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gsrc_q       <= 1'b0;
      toggle_q     <= 1'b0;
      gate_value_q <= 1'b0;
    end
    else
    begin
      gsrc_q       <= gsrc;
      gate_value_q <= gate_cur;
      // Leaving toggle mode clears the flop, so a new enable starts closed
      if (!gate_toggle_mode)
        toggle_q <= 1'b0;                                                  // [R5]
      else if (gate_rise)
        toggle_q <= !toggle_q;                                             // [R5]
    end
  end

  // Pulse opens on the first active edge after arming. In toggle mode it
  // closes on the next rising edge, otherwise when the active level ends.
  wire pulse_open  = gate_rise && !pulse_q;
  wire pulse_close = gate_toggle_mode ? gate_rise : !gpol;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_q <= 1'b0;
    else if (!gate_single_pulse_mode || !go_done)
      pulse_q <= 1'b0;                                                     // [R6]
    else if (pulse_open)
      pulse_q <= 1'b1;                                                     // [R7]
    else if (pulse_q && pulse_close)
      pulse_q <= 1'b0;                                                     // [R6]
  end

  // Set by software, hardware clear on falling gate value
  // Writing zero never clears the go bit; leaving single-pulse mode does
  wire go_write = wr_gc && pwdata[tgc_pkg::GO_BIT];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      go_done <= 1'b0;
    else if (!gate_single_pulse_mode)
      go_done <= 1'b0;
    else if (go_write)
      go_done <= 1'b1;                                                     // [R7]
    else if (gval_fall)
      go_done <= 1'b0;                                                     // [R9]
  end

  // ****************************************
  // Counter
  // ****************************************
  wire gate_ok  = !gate_enable || gate_cur;                                // [R4]
  wire count_en = timer_run && gate_ok;                                    // [R3]
  logic pre_tick;

  // Prescaler restarts from zero whenever the timer is stopped
  tgc_prescaler u_prescaler
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .ratio    (input_prescale_select),                                     // [R1]
    .clear    (!timer_run),
    .tick_in  (src_tick && count_en),
    .tick_out (pre_tick)
  );

  wire wr_cl    = wr_en && hit_cl && lane0;
  wire wr_ch    = wr_en && hit_ch && lane0;
  // Overflow only on a real increment; a software byte write wins over it
  wire wrap     = pre_tick && !wr_cl && !wr_ch && (count == 16'hFFFF);     // [R11]
  wire [15:0] next_count = count + 16'h0001;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 16'h0000;
    else if (wr_cl)
      count[7:0] <= pwdata[7:0];
    else if (wr_ch)
      count[15:8] <= pwdata[7:0];
    else if (pre_tick)
      count <= next_count;                                                 // [R11]
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Go and gate value bits are not stored here: they read from live state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control      <= tgc_pkg::RESET_BYTE;
      timer_gate_control <= tgc_pkg::RESET_BYTE;
      irq_mask           <= tgc_pkg::RESET_IRQ;
    end
    else
    begin
      if (wr_tc)
        timer_control <= pwdata[7:0] & tgc_pkg::TIMER_CONTROL_MASK;
      if (wr_gc)
        timer_gate_control <= pwdata[7:0] & tgc_pkg::GATE_CONTROL_MASK;
      if (wr_im)
        irq_mask <= pwdata[1:0];
    end
  end

  // Plain level; oscillator start-up time is outside this block
  assign low_power_osc_on = low_power_osc_enable;                           // [R2]

  // ****************************************
  // Interrupts
  // ****************************************
  // Set beats the clear-on-read in the same cycle. Only the bits that the
  // read captured in its setup cycle are cleared, so an event landing
  // between setup and access stays for the next read.
  wire [1:0] irq_set   = {gval_fall, wrap};                                 // [R10] [R11]
  wire       rd_is     = rd_en && hit_is;
  wire [1:0] irq_clear = rd_is ? prdata[1:0] : 2'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= tgc_pkg::RESET_IRQ;
    else
      irq_status <= (irq_status & ~irq_clear) | irq_set;                    // [R10]
  end

  // Level output: high while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Read data
  // ****************************************
  wire [7:0] gc_read = {timer_gate_control[7:4], go_done, gate_value_q,
                        timer_gate_control[1:0]};                           // [R13]
  wire [31:0] rd_mux =
      hit_tc ? {24'h000000, timer_control}
    : hit_gc ? {24'h000000, gc_read}
    : hit_cl ? {24'h000000, count[7:0]}
    : hit_ch ? {24'h000000, count[15:8]}
    : hit_is ? {30'h0, irq_status}
    : hit_im ? {30'h0, irq_mask}
    : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule : tgc_timer

/* pkg/tgc_pkg.sv */
package tgc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_GATE_CONTROL  = 12'h004;
  localparam logic [11:0] ADDR_COUNT_LOW     = 12'h008;
  localparam logic [11:0] ADDR_COUNT_HIGH    = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK      = 12'h014;

  // ****************************************
  // Timer control fields
  // ****************************************
  localparam int CS_LSB     = 6;
  localparam int CKPS_LSB   = 4;
  localparam int OSCEN_BIT  = 3;
  localparam int SYNCN_BIT  = 2;
  localparam int RUN_BIT    = 0;
  localparam logic [7:0] TIMER_CONTROL_MASK = 8'hFD;

  // ****************************************
  // Gate control fields
  // ****************************************
  localparam int GE_BIT     = 7;
  localparam int GPOL_BIT   = 6;
  localparam int GTM_BIT    = 5;
  localparam int GSPM_BIT   = 4;
  localparam int GO_BIT     = 3;
  localparam int GVAL_BIT   = 2;
  localparam int GSS_LSB    = 0;
  localparam logic [7:0] GATE_CONTROL_MASK = 8'hF3;

  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int IRQ_OVF_BIT  = 0;
  localparam int IRQ_GATE_BIT = 1;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] CS_SYSCLK  = 2'h0;
  localparam logic [1:0] GSS_PIN    = 2'h0;
  localparam logic [1:0] GSS_TMR8   = 2'h1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_IRQ  = 2'h0;

endpackage : tgc_pkg

/* hdl/tgc_prescaler.sv */
`timescale 1ns/1ps

// Divides a one-cycle tick stream by 1, 2, 4 or 8
module tgc_prescaler
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [1:0] ratio,
  input  wire logic       clear,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [2:0] count;
  logic [2:0] limit;

  assign limit    = 3'((4'h1 << ratio) - 4'h1);
  assign tick_out = tick_in && (count == limit);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 3'h0;
    else if (clear || tick_out)
      count <= 3'h0;
    else if (tick_in)
      count <= count + 3'h1;
  end

endmodule : tgc_prescaler

/* testbench/tgc_timer_assertions.sv */
`timescale 1ns/1ps
// ****
// Port checker
// ****
module tgc_timer_assertions
(
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and interrupt
  input wire logic        ext_clock_pin,
  input wire logic        gate_pin,
  input wire logic        tmr8_overflow,
  input wire logic        low_power_osc_on,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       acc = psel && penable;
  wire       rs  = psel && !penable && !pwrite;
  wire       hit = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h5;
  wire       wr0 = acc && pwrite && pstrb[0];
  wire       cw  = wr0 && paddr == tgc_pkg::ADDR_TIMER_CONTROL;
  logic [1:0] msk;
  // Shadow of the mask, so irq can be judged from the ports
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) msk <= 2'h0;
    else if (wr0 && paddr == tgc_pkg::ADDR_IRQ_MASK) msk <= pwdata[1:0];
  sequence s_cw; cw; endsequence
  sequence s_crd; rs && paddr == tgc_pkg::ADDR_TIMER_CONTROL; endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no slave error");
  a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("bad slave error");
  a_read_unmapped: assert property (rs && !hit |=> prdata == 32'h0) else $error("unmapped data");
  a_read_holds: assert property (!rs |=> $stable(prdata)) else $error("prdata moved");
  a_osc_follows: assert property (s_cw |=> low_power_osc_on == $past(pwdata[3]))
    else $error("osc enable not applied");
  a_osc_holds: assert property (!cw |=> $stable(low_power_osc_on))
    else $error("osc enable moved");
  a_ctrl_back: assert property (s_cw ##2 s_crd |=>
    prdata[7:0] == ($past(pwdata[7:0], 3) & tgc_pkg::TIMER_CONTROL_MASK))
    else $error("control readback wrong");
  a_irq_masked: assert property (msk == 2'h0 && $past(msk) == 2'h0 |-> !irq)
    else $error("masked irq high");
endmodule : tgc_timer_assertions

bind tgc_timer tgc_timer_assertions i_tgc_timer_assertions (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_clock_pin(ext_clock_pin), .gate_pin(gate_pin), .tmr8_overflow(tmr8_overflow),
  .low_power_osc_on(low_power_osc_on), .irq(irq));

/* testbench/tgc_gate_model.sv */
`timescale 1ns/1ps
// ****
// Gate sources and external clock
// ****
module tgc_gate_model
(
  // Clock
  input wire logic pclk,
  // Requests
  input wire logic gate_lvl,
  input wire logic ovf_lvl,
  input wire logic ext_en,
  // Pins
  output logic     gate_pin = 1'b0,
  output logic     tmr8_overflow = 1'b0,
  output logic     ext_clock_pin = 1'b0
);
  logic [2:0] div = 3'h0;
  // Gate pin is asynchronous, so it moves away from the sampling edge
  always @(negedge pclk) gate_pin <= gate_lvl;
  always @(posedge pclk) tmr8_overflow <= ovf_lvl;
  // Rising edge every 6 cycles, held low while disabled
  always @(posedge pclk)
  begin
    div           <= (ext_en && div != 3'h5) ? div + 3'h1 : 3'h0;
    ext_clock_pin <= ext_en && div > 3'h2;
  end
endmodule : tgc_gate_model

/* testbench/tgc_timer_tb_top.sv */
`timescale 1ns/1ps
module tgc_timer_tb_top;
  // ****
  // Signals
  // ****
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        gate_lvl = 1'b0, ovf_lvl = 1'b0, ext_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, ext_clock_pin, gate_pin, tmr8_overflow, low_power_osc_on, irq;
  logic [7:0]  d, k;
  int          n_errors = 0, tests_run = 0, w, i;
  // Rows: gate control, {overflow, pin}, counts expected
  logic [10:0] gtab [8] = '{11'h001, 11'h600, 11'h603, 11'h401,
                            11'h402, 11'h60A, 11'h60D, 11'h616};
  always #2.5 pclk = ~pclk;
  tgc_timer i_tgc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .gate_pin(gate_pin),
    .tmr8_overflow(tmr8_overflow), .low_power_osc_on(low_power_osc_on), .irq(irq));
  tgc_gate_model i_tgc_gate_model (.pclk(pclk), .gate_lvl(gate_lvl), .ovf_lvl(ovf_lvl),
    .ext_en(ext_en), .gate_pin(gate_pin), .tmr8_overflow(tmr8_overflow),
    .ext_clock_pin(ext_clock_pin));
  // ****
  // Tasks
  // ****
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic bit near(input logic [7:0] v, input int e);
    return v >= e - 2 && v <= e + 2;
  endfunction : near
  task automatic pulse;
    gate_lvl <= 1'b1;
    repeat (6) @(posedge pclk);
    gate_lvl <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse
  task summarize;
    $display("mismatches %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // ****
  // Tests
  // ****
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h474c));
    for (i = 0; i < 7; i++)
    begin
      bus(1'b0, 12'(i * 4), 8'h00);
      chk("reset value", d & (i == 1 ? 8'hFB : 8'hFF), 8'h00);
    end
    $display("test reset done");
    k = 8'($urandom) & 8'h3C;
    bus(1'b1, 12'h000, k);
    bus(1'b0, 12'h000, 8'h00);
    chk("control", d, k);
    chk("osc on", low_power_osc_on, k[3]);
    bus(1'b1, 12'h000, 8'h08);
    bus(1'b1, 12'h000, 8'h00);
    bus(1'b0, 12'h000, 8'h00);
    chk("osc off", low_power_osc_on, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, 12'h008, 8'h00);
      bus(1'b1, 12'h00C, 8'h00);
      w = 40 + $urandom % 40;
      bus(1'b1, 12'h000, 8'(i * 16 + 1));
      repeat (w) @(posedge pclk);
      bus(1'b1, 12'h000, 8'h00);
      bus(1'b0, 12'h008, 8'h00);
      chk("prescaled count", near(d, (w + 2) >> i), 1'b1);
    end
    k = 8'($urandom);
    bus(1'b1, 12'h008, k);
    repeat (30) @(posedge pclk);
    pstrb <= 4'hE;
    bus(1'b1, 12'h008, ~k);
    pstrb <= 4'hF;
    bus(1'b0, 12'h008, 8'h00);
    chk("held count", d, k);
    $display("test counting done");
    for (i = 0; i < 8; i++)
    begin
      ovf_lvl  <= gtab[i][2];
      gate_lvl <= gtab[i][1];
      bus(1'b1, 12'h004, gtab[i][10:3]);
      bus(1'b1, 12'h008, 8'h00);
      repeat (8) @(posedge pclk);
      bus(1'b1, 12'h000, 8'h01);
      repeat (40) @(posedge pclk);
      bus(1'b1, 12'h000, 8'h00);
      bus(1'b0, 12'h008, 8'h00);
      chk("gated count", d > 8'h10, gtab[i][0]);
    end
    {ovf_lvl, gate_lvl} <= 2'b00;
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 12'h004, 8'h00);
      bus(1'b1, 12'h008, 8'h00);
      ext_en <= 1'b1;
      bus(1'b1, 12'h000, 8'(8'h81 | i * 4));
      repeat (118) @(posedge pclk);
      bus(1'b1, 12'h000, 8'h00);
      ext_en <= 1'b0;
      bus(1'b0, 12'h008, 8'h00);
      chk("external count", near(d, 20), 1'b1);
    end
    $display("test gate done");
    bus(1'b1, 12'h004, 8'hE0);
    pulse();
    bus(1'b0, 12'h004, 8'h00);
    chk("toggle set", d[2], 1'b1);
    pulse();
    bus(1'b0, 12'h004, 8'h00);
    chk("toggle back", d[2], 1'b0);
    pulse();
    bus(1'b1, 12'h004, 8'hC0);
    bus(1'b0, 12'h004, 8'h00);
    chk("toggle cleared", d[2], 1'b0);
    bus(1'b1, 12'h004, 8'hE0);
    bus(1'b0, 12'h004, 8'h00);
    chk("toggle restart", d[2], 1'b0);
    bus(1'b0, 12'h010, 8'h00);
    bus(1'b1, 12'h014, 8'h00);
    bus(1'b1, 12'h004, 8'hD0);
    bus(1'b1, 12'h004, 8'hD8);
    bus(1'b0, 12'h004, 8'h00);
    chk("armed", d[3], 1'b1);
    pulse();
    bus(1'b0, 12'h004, 8'h00);
    chk("done", d[3], 1'b0);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, 12'h014, 8'h02);
    repeat (2) @(posedge pclk);
    chk("irq raised", irq, 1'b1);
    bus(1'b0, 12'h010, 8'h00);
    chk("gate event", d[1:0], 2'b10);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, 12'h004, 8'h88);
    bus(1'b0, 12'h004, 8'h00);
    chk("go without pulse mode", d[3], 1'b0);
    $display("test pulse done");
    bus(1'b1, 12'h00C, 8'hFF);
    bus(1'b1, 12'h008, 8'hF0);
    bus(1'b0, 12'h010, 8'h00);
    bus(1'b1, 12'h000, 8'h01);
    repeat (30) @(posedge pclk);
    bus(1'b1, 12'h000, 8'h00);
    bus(1'b0, 12'h00C, 8'h00);
    chk("wrapped high", d, 8'h00);
    bus(1'b0, 12'h010, 8'h00);
    chk("overflow flag", d[0], 1'b1);
    $display("test overflow done");
    summarize();
  end
endmodule : tgc_timer_tb_top
